// [core/dlt_pkg.sv]
package dlt_pkg;

  // ----------------------------------------------------------------
  // bus and clock
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ     = 40_000_000;
  localparam int unsigned ADDR_W     = 9;
  localparam logic [1:0]  RESP_OKAY  = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // register indices; byte address is four times the index
  localparam logic [6:0] IDX_T0_CNT  = 7'h50;
  localparam logic [6:0] IDX_T0_LIMA = 7'h52;
  localparam logic [6:0] IDX_T0_LIMB = 7'h54;
  localparam logic [6:0] IDX_T0_MODE = 7'h56;
  localparam logic [6:0] IDX_T1_CNT  = 7'h58;
  localparam logic [6:0] IDX_T1_LIMA = 7'h5a;
  localparam logic [6:0] IDX_T1_LIMB = 7'h5c;
  localparam logic [6:0] IDX_T1_MODE = 7'h5e;
  localparam logic [6:0] IDX_T2_CNT  = 7'h60;
  localparam logic [6:0] IDX_T2_LIMA = 7'h62;
  localparam logic [6:0] IDX_T2_MODE = 7'h66;

  // ----------------------------------------------------------------
  // mode/control field positions
  // ----------------------------------------------------------------
  localparam int BIT_EN      = 15;
  localparam int BIT_GUARD   = 14;
  localparam int BIT_INT     = 13;
  localparam int BIT_IN_USE  = 12;
  localparam int BIT_MAX_HIT = 5;
  localparam int BIT_RETRIG  = 4;
  localparam int BIT_PSC     = 3;
  localparam int BIT_EXT     = 2;
  localparam int BIT_DUAL    = 1;
  localparam int BIT_RUN_ON  = 0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam logic [1:0]  PHASE_LAST       = 2'h3;
  localparam int unsigned OUT_LAG_CLKS     = 6;
  localparam int unsigned EXT_SPACING_CLKS = 4;
  localparam logic [1:0]  T2_IDX           = 2'h2;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    REG_CNT  = 2'h0,
    REG_LIMA = 2'h1,
    REG_LIMB = 2'h2,
    REG_MODE = 2'h3
  } dlt_kind_type;

  typedef enum logic [1:0] {
    WR_IDLE = 2'h1,
    WR_RESP = 2'h2
  } dlt_wr_type;

  typedef struct packed {
    logic         hit;
    logic [1:0]   idx;
    dlt_kind_type kind;
  } dlt_sel_type;

  typedef struct packed {
    logic        en;
    logic        int_en;
    logic        in_use;
    logic        max_hit;
    logic        retrig;
    logic        psc;
    logic        ext;
    logic        dual;
    logic        run_on;
    logic        armed;
    logic        pulse;
    logic [15:0] count;
    logic [15:0] lim_a;
    logic [15:0] lim_b;
  } dlt_tmr_type;

  typedef struct packed {
    dlt_tmr_type [2:0]     tmr;
    logic [1:0][2:0]       sync;
    logic [1:0]            level;
    logic [1:0]            phase;
    logic [1:0]            out;
    logic [2:0]            irq;
    logic                  aw_ok;
    logic                  w_ok;
    logic [ADDR_W-1:0]     awaddr;
    logic [31:0]           wdata;
    logic [3:0]            wstrb;
    dlt_wr_type            wr;
    logic [1:0]            bresp;
    logic                  rvalid;
    logic [31:0]           rdata;
    logic [1:0]            rresp;
  } dlt_state_type;

  function automatic dlt_state_type reset_state();
    reset_state             = '0;
    reset_state.tmr[0].dual = 1'b1;
    reset_state.tmr[1].dual = 1'b1;
    reset_state.out         = 2'h3;
    reset_state.wr          = WR_IDLE;
  endfunction

endpackage

// [core/dlt_timer.sv]
// Chosen here: the register offsets and the AXI4-Lite interface to the registers.
module dlt_timer (
  // clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // axi4-lite write address
  input  wire logic [dlt_pkg::ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                s_axi_awprot,
  input  wire logic                      s_axi_awvalid,
  output logic                           s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]               s_axi_wdata,
  input  wire logic [3:0]                s_axi_wstrb,
  input  wire logic                      s_axi_wvalid,
  output logic                           s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                     s_axi_bresp,
  output logic                           s_axi_bvalid,
  input  wire logic                      s_axi_bready,
  // axi4-lite read address
  input  wire logic [dlt_pkg::ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                s_axi_arprot,
  input  wire logic                      s_axi_arvalid,
  output logic                           s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                    s_axi_rdata,
  output logic [1:0]                     s_axi_rresp,
  output logic                           s_axi_rvalid,
  input  wire logic                      s_axi_rready,
  // timer pins, timers 0 and 1
  input  wire logic [1:0]                timer_in,
  output logic [1:0]                     timer_out,
  // terminal-count requests toward the interrupt controller
  output logic [2:0]                     irq_req
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic dlt_pkg::dlt_sel_type decode(input logic [dlt_pkg::ADDR_W-1:0] a);
    logic [6:0] ix;
    ix     = a[dlt_pkg::ADDR_W-1:2];
    decode = '0;
    if (ix == dlt_pkg::IDX_T0_CNT) begin
      decode = '{1'b1, 2'h0, dlt_pkg::REG_CNT};
    end else if (ix == dlt_pkg::IDX_T0_LIMA) begin
      decode = '{1'b1, 2'h0, dlt_pkg::REG_LIMA};
    end else if (ix == dlt_pkg::IDX_T0_LIMB) begin
      decode = '{1'b1, 2'h0, dlt_pkg::REG_LIMB};
    end else if (ix == dlt_pkg::IDX_T0_MODE) begin
      decode = '{1'b1, 2'h0, dlt_pkg::REG_MODE};
    end else if (ix == dlt_pkg::IDX_T1_CNT) begin
      decode = '{1'b1, 2'h1, dlt_pkg::REG_CNT};
    end else if (ix == dlt_pkg::IDX_T1_LIMA) begin
      decode = '{1'b1, 2'h1, dlt_pkg::REG_LIMA};
    end else if (ix == dlt_pkg::IDX_T1_LIMB) begin
      decode = '{1'b1, 2'h1, dlt_pkg::REG_LIMB};
    end else if (ix == dlt_pkg::IDX_T1_MODE) begin
      decode = '{1'b1, 2'h1, dlt_pkg::REG_MODE};
    end else if (ix == dlt_pkg::IDX_T2_CNT) begin
      decode = '{1'b1, dlt_pkg::T2_IDX, dlt_pkg::REG_CNT};
    end else if (ix == dlt_pkg::IDX_T2_LIMA) begin
      decode = '{1'b1, dlt_pkg::T2_IDX, dlt_pkg::REG_LIMA};
    end else if (ix == dlt_pkg::IDX_T2_MODE) begin
      decode = '{1'b1, dlt_pkg::T2_IDX, dlt_pkg::REG_MODE};
    end
  endfunction

  function automatic logic [15:0] mode_word(input dlt_pkg::dlt_tmr_type t);
    mode_word = '0;
    mode_word[dlt_pkg::BIT_EN]      = t.en;
    mode_word[dlt_pkg::BIT_INT]     = t.int_en;
    mode_word[dlt_pkg::BIT_IN_USE]  = t.in_use;
    mode_word[dlt_pkg::BIT_MAX_HIT] = t.max_hit;
    mode_word[dlt_pkg::BIT_RETRIG]  = t.retrig;
    mode_word[dlt_pkg::BIT_PSC]     = t.psc;
    mode_word[dlt_pkg::BIT_EXT]     = t.ext;
    mode_word[dlt_pkg::BIT_DUAL]    = t.dual;
    mode_word[dlt_pkg::BIT_RUN_ON]  = t.run_on;
  endfunction

  function automatic logic [15:0] reg_word(input dlt_pkg::dlt_tmr_type t, input dlt_pkg::dlt_kind_type k);
    if (k == dlt_pkg::REG_CNT) begin
      reg_word = t.count;
    end else if (k == dlt_pkg::REG_LIMA) begin
      reg_word = t.lim_a;
    end else if (k == dlt_pkg::REG_LIMB) begin
      reg_word = t.lim_b;
    end else begin
      reg_word = mode_word(t);
    end
  endfunction

  // only the two low byte lanes carry register bits
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] st);
    merge16 = {st[1] ? wd[15:8] : old[15:8], st[0] ? wd[7:0] : old[7:0]};
  endfunction

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dlt_pkg::dlt_state_type q;
  dlt_pkg::dlt_state_type d;
  dlt_pkg::dlt_sel_type   sel_w;
  logic                   wr_now;
  logic [2:0]             max_set;

  assign sel_w  = decode(q.awaddr);
  assign wr_now = q.aw_ok && q.w_ok && (q.wr == dlt_pkg::WR_IDLE);

  always_comb begin
    dlt_pkg::dlt_tmr_type t;
    dlt_pkg::dlt_sel_type sr;
    logic [15:0]          nxt;
    logic [15:0]          lim;
    logic [15:0]          v;
    logic [2:0]           gate;
    logic [2:0]           rise;
    logic                 step;
    logic                 slot;
    logic                 t2_tc;
    t      = '0;
    sr     = '0;
    nxt    = '0;
    lim    = '0;
    v      = '0;
    step   = 1'b0;
    t2_tc  = 1'b0;
    max_set = '0;
    d      = q;
    d.irq  = '0;

    // pin inputs: three flops, change accepted when second and third agree
    // three flop sync
    gate = {1'b1, q.level};
    rise = '0;
    for (int p = 0; p < 2; p++) begin
      d.sync[p] = {q.sync[p][1:0], timer_in[p]};
      if (q.sync[p][1] == q.sync[p][2]) begin
        d.level[p] = q.sync[p][2];
        rise[p]    = q.sync[p][2] & ~q.level[p];
      end
    end

    // counting steps once every four clocks, or with prescale on timer 2 terminal count only; external-event mode steps on the rise itself
    d.phase = 2'(q.phase + 2'h1);
    slot    = (q.phase == dlt_pkg::PHASE_LAST);

    // timer 2 runs first so its terminal count can prescale 0 and 1
    for (int i = 2; i >= 0; i--) begin
      t       = q.tmr[i];
      t.pulse = 1'b0;
      step    = 1'b0;
      if (!t.en) begin
        t.armed = 1'b0;
      end else if (t.ext) begin
        step = rise[i];
      end else if (t.retrig) begin
        if (rise[i]) begin
          t.count = '0;
          t.armed = 1'b1;
        end else begin
          step = t.armed && slot && (t.psc ? t2_tc : 1'b1);
        end
      end else begin
        step = gate[i] && slot && (t.psc ? t2_tc : 1'b1);
      end
      if (step) begin
        nxt = 16'(t.count + 16'h1);
        lim = (t.dual && t.in_use) ? t.lim_b : t.lim_a;
        // equality with active limit; a limit below count wraps first
        if (nxt == lim) begin
          t.count   = '0;
          t.max_hit  = 1'b1;
          max_set[i] = 1'b1;
          d.irq[i]   = t.int_en;
          t.pulse    = ~t.dual;
          if (!t.run_on && (!t.dual || t.in_use)) begin
            t.en = 1'b0;
          end
          t.in_use = t.dual & ~t.in_use;
          if (i == 2) begin
            t2_tc = 1'b1;
          end
        end else begin
          t.count = nxt;
        end
      end
      d.tmr[i] = t;
    end

    // output waveform, one clock behind the count
    for (int p = 0; p < 2; p++) begin
      d.out[p] = q.tmr[p].dual ? ~q.tmr[p].in_use : ~q.tmr[p].pulse;
    end

    // ----------------------------------------------------------------
    // axi4-lite write
    // ----------------------------------------------------------------
    if (s_axi_awvalid && !q.aw_ok && (q.wr == dlt_pkg::WR_IDLE)) begin
      d.aw_ok  = 1'b1;
      d.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !q.w_ok && (q.wr == dlt_pkg::WR_IDLE)) begin
      d.w_ok  = 1'b1;
      d.wdata = s_axi_wdata;
      d.wstrb = s_axi_wstrb;
    end
    case (q.wr)
      dlt_pkg::WR_IDLE: begin
        if (wr_now) begin
          d.aw_ok = 1'b0;
          d.w_ok  = 1'b0;
          d.wr    = dlt_pkg::WR_RESP;
          d.bresp = dlt_pkg::RESP_SLVERR;
          if (sel_w.hit) begin
            d.bresp = dlt_pkg::RESP_OKAY;
            t = d.tmr[sel_w.idx];
            v = merge16(reg_word(q.tmr[sel_w.idx], sel_w.kind), q.wdata, q.wstrb);
            case (sel_w.kind)
              dlt_pkg::REG_CNT:  t.count = v;
              dlt_pkg::REG_LIMA: t.lim_a = v;
              dlt_pkg::REG_LIMB: t.lim_b = v;
              default: begin
                if (v[dlt_pkg::BIT_GUARD]) begin
                  t.en = v[dlt_pkg::BIT_EN];
                end
                t.int_en  = v[dlt_pkg::BIT_INT];
                t.run_on  = v[dlt_pkg::BIT_RUN_ON];
                t.max_hit = max_set[sel_w.idx] | (q.tmr[sel_w.idx].max_hit & v[dlt_pkg::BIT_MAX_HIT]);
                if (sel_w.idx != dlt_pkg::T2_IDX) begin
                  t.retrig = v[dlt_pkg::BIT_RETRIG];
                  t.psc    = v[dlt_pkg::BIT_PSC];
                  t.ext    = v[dlt_pkg::BIT_EXT];
                  t.dual   = v[dlt_pkg::BIT_DUAL];
                end
                // flag not written, cleared without alternating
                t.in_use = t.in_use & t.dual;
              end
            endcase
            d.tmr[sel_w.idx] = t;
          end
        end
      end
      dlt_pkg::WR_RESP: begin
        if (s_axi_bready) begin
          d.wr = dlt_pkg::WR_IDLE;
        end
      end
      default: d.wr = dlt_pkg::WR_IDLE;
    endcase

    // ----------------------------------------------------------------
    // axi4-lite read
    // ----------------------------------------------------------------
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && !q.rvalid) begin
      sr       = decode(s_axi_araddr);
      d.rvalid = 1'b1;
      d.rdata  = '0;
      d.rresp  = dlt_pkg::RESP_SLVERR;
      if (sr.hit) begin
        d.rdata[15:0] = reg_word(q.tmr[sr.idx], sr.kind);
        d.rresp       = dlt_pkg::RESP_OKAY;
      end
    end
  end

  // alternating set on timers 0 and 1, flag cleared on reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= dlt_pkg::reset_state();
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = !q.aw_ok && (q.wr == dlt_pkg::WR_IDLE);
  assign s_axi_wready  = !q.w_ok && (q.wr == dlt_pkg::WR_IDLE);
  assign s_axi_bvalid  = (q.wr == dlt_pkg::WR_RESP);
  assign s_axi_bresp   = q.bresp;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign timer_out     = q.out;
  assign irq_req       = q.irq;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_in_use_zero;
    !q.tmr[0].dual |-> !q.tmr[0].in_use;
  endproperty
  a_in_use_zero: assert property (p_in_use_zero) else $error("in-use flag set without alternating");

  property p_max_sticky;
    $fell(q.tmr[1].max_hit) |-> $past(wr_now && sel_w.hit && sel_w.idx == 2'h1 && sel_w.kind == dlt_pkg::REG_MODE);
  endproperty
  a_max_sticky: assert property (p_max_sticky) else $error("max flag cleared without mode write");

  property p_max_on_tc;
    q.tmr[0].pulse |-> q.tmr[0].max_hit;
  endproperty
  a_max_on_tc: assert property (p_max_on_tc) else $error("max flag missing at terminal count");

  property p_zero_on_tc;
    q.irq[2] && !$past(wr_now) |-> q.tmr[2].count == 16'h0000;
  endproperty
  a_zero_on_tc: assert property (p_zero_on_tc) else $error("count not zero at terminal count");

  property p_low_pulse;
    q.tmr[0].pulse && !q.tmr[0].dual |=> !timer_out[0] ##1 (timer_out[0] || q.tmr[0].dual || $past(q.tmr[0].pulse));
  endproperty
  a_low_pulse: assert property (p_low_pulse) else $error("single-limit output pulse wrong");

  property p_halt_single;
    q.tmr[0].pulse && !q.tmr[0].run_on && !$past(wr_now) |-> !q.tmr[0].en;
  endproperty
  a_halt_single: assert property (p_halt_single) else $error("single run did not halt");

  property p_t2_fixed;
    !q.tmr[2].dual && !q.tmr[2].ext && !q.tmr[2].psc && !q.tmr[2].retrig && !q.tmr[2].in_use;
  endproperty
  a_t2_fixed: assert property (p_t2_fixed) else $error("timer 2 fixed bits not zero");

  property p_idle_hold;
    !q.tmr[1].en && !wr_now |=> $stable(q.tmr[1].count);
  endproperty
  a_idle_hold: assert property (p_idle_hold) else $error("disabled timer changed count");

  property p_quarter_rate;
    $changed(q.tmr[2].count) && !$past(wr_now) |-> $past(q.phase) == dlt_pkg::PHASE_LAST;
  endproperty
  a_quarter_rate: assert property (p_quarter_rate) else $error("timer 2 stepped off its slot");

  property p_reset_state;
    $past(!aresetn) |-> !q.tmr[0].en && !q.tmr[2].en && q.tmr[1].dual && !q.tmr[1].in_use && timer_out == 2'h3;
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("reset state wrong");

endmodule

// [verif/dlt_event_src.sv]
module dlt_event_src (
  // clock
  input  wire logic       aclk,
  // pins toward timers 0 and 1
  output logic      [1:0] timer_in
);
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // event and gate driver
  // ----------------------------------------------------------------
  // pins idle low; nothing floats because this source always drives
  initial timer_in = 2'h0;

  task automatic pulse(input int idx, input int n);
    repeat (n) begin
      @(posedge aclk);
      timer_in[idx] <= 1'b1;
      repeat (dlt_pkg::EXT_SPACING_CLKS / 2) @(posedge aclk);
      timer_in[idx] <= 1'b0;
      repeat (dlt_pkg::EXT_SPACING_CLKS / 2) @(posedge aclk);
    end
  endtask

  task automatic gate(input int idx, input logic v);
    @(posedge aclk);
    timer_in[idx] <= v;
  endtask
endmodule

// [verif/dual_limit_timer_tb.sv]
module dual_limit_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic                        aclk, aresetn;
  logic [dlt_pkg::ADDR_W-1:0]  s_axi_awaddr, s_axi_araddr;
  logic [2:0]                  s_axi_awprot, s_axi_arprot, irq_req;
  logic [31:0]                 s_axi_wdata, s_axi_rdata;
  logic [3:0]                  s_axi_wstrb;
  logic [1:0]                  s_axi_bresp, s_axi_rresp, timer_in, timer_out;
  logic                        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic                        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic                        s_axi_rvalid, s_axi_rready;
  int                          n_fail, checks_done, low0, irq1;

  dlt_timer uut (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_in, .timer_out, .irq_req
  );
  dlt_event_src ev (.aclk, .timer_in);

  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // outputs counted mid-cycle, away from the edge that moves them
  always @(negedge aclk) begin
    if (timer_out[0] === 1'b0) low0++;
    if (irq_req[1] === 1'b1) irq1++;
  end

  // ----------------------------------------------------------------
  // bus tasks and checks
  // ----------------------------------------------------------------
  function automatic logic [8:0] ba(input logic [6:0] i);
    return {i, 2'h0};
  endfunction

  task automatic summarize();
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [17:0] g, input logic [17:0] lo, input logic [17:0] hi);
    checks_done++;
    if ((g >= lo && g <= hi) !== 1'b1) begin
      n_fail++;
      $display("ERROR t=%0t got %h want %h..%h", $time, g, lo, hi);
    end
  endtask

  task automatic tmo();
    n_fail++;
    $display("ERROR t=%0t bus wait ran out", $time);
    summarize();
  endtask

  // handshakes are judged at the negedge so the edge itself never races the design
  task automatic wr(input logic [8:0] a, input logic [15:0] d, input logic [1:0] er);
    logic ao, wo, bo;
    logic [1:0] r;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {16'h0000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    bo = 1'b0;
    for (int k = 0; k < 40 && !bo; k++) begin
      @(negedge aclk);
      ao = s_axi_awvalid & s_axi_awready;
      wo = s_axi_wvalid & s_axi_wready;
      bo = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (ao) s_axi_awvalid <= 1'b0;
      if (wo) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b0;
    if (!bo) tmo();
    chk({r, 16'h0000}, {er, 16'h0000}, {er, 16'h0000});
  endtask

  task automatic rd(input logic [8:0] a, output logic [15:0] d, output logic [1:0] r);
    logic ao, ro;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ro = 1'b0;
    for (int k = 0; k < 40 && !ro; k++) begin
      @(negedge aclk);
      ao = s_axi_arvalid & s_axi_arready;
      ro = s_axi_rvalid;
      d = s_axi_rdata[15:0];
      r = s_axi_rresp;
      @(posedge aclk);
      if (ao) s_axi_arvalid <= 1'b0;
    end
    s_axi_rready <= 1'b0;
    if (!ro) tmo();
  endtask

  task automatic rc(input logic [8:0] a, input logic [15:0] e);
    logic [15:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk({r, d}, {dlt_pkg::RESP_OKAY, e}, {dlt_pkg::RESP_OKAY, e});
  endtask

  task automatic meas(input int w, input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] c1, c2;
    logic [1:0] r;
    rd(ba(dlt_pkg::IDX_T0_CNT), c1, r);
    repeat (w) @(posedge aclk);
    rd(ba(dlt_pkg::IDX_T0_CNT), c2, r);
    chk({2'h0, c2 - c1}, {2'h0, lo}, {2'h0, hi});
  endtask

  // pin effects are read after the six clock lag has run out
  task automatic lag();
    repeat (dlt_pkg::OUT_LAG_CLKS + 2) @(posedge aclk);
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [15:0] d;
    logic [1:0] r;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rc(ba(dlt_pkg::IDX_T0_MODE), 16'h0002);
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'h0002);
    rc(ba(dlt_pkg::IDX_T2_MODE), 16'h0000);
    chk({16'h0, timer_out}, 18'h3, 18'h3);
    // timer 2 has no limit b, so its slot is unmapped
    rd(9'h190, d, r);
    chk({r, d}, {dlt_pkg::RESP_SLVERR, 16'h0}, {dlt_pkg::RESP_SLVERR, 16'h0});
    wr(9'h190, 16'h1234, dlt_pkg::RESP_SLVERR);
    wr(ba(dlt_pkg::IDX_T2_CNT), 16'h0000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T2_LIMA), 16'h0003, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T2_MODE), 16'he01f, dlt_pkg::RESP_OKAY);
    rd(ba(dlt_pkg::IDX_T2_MODE), d, r);
    chk({2'h0, d & 16'hffdf}, 18'ha001, 18'ha001);
    wr(ba(dlt_pkg::IDX_T0_CNT), 16'h0000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_LIMA), 16'hf000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'hc001, dlt_pkg::RESP_OKAY);
    meas(40, 16'h0, 16'h0);
    ev.gate(0, 1'b1);
    meas(40, 16'd10, 16'd11);
    wr(ba(dlt_pkg::IDX_T0_CNT), 16'h0200, dlt_pkg::RESP_OKAY);
    rd(ba(dlt_pkg::IDX_T0_CNT), d, r);
    chk({2'h0, d}, 18'h200, 18'h202);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'hc009, dlt_pkg::RESP_OKAY);
    meas(120, 16'd10, 16'd11);
    ev.gate(0, 1'b0);
    lag();
    meas(40, 16'h0, 16'h0);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'h4000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_CNT), 16'h0100, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'hc011, dlt_pkg::RESP_OKAY);
    repeat (20) @(posedge aclk);
    rc(ba(dlt_pkg::IDX_T0_CNT), 16'h0100);
    ev.pulse(0, 1);
    rd(ba(dlt_pkg::IDX_T0_CNT), d, r);
    chk({2'h0, d}, 18'h0, 18'h3);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'h4000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_CNT), 16'h0000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_LIMA), 16'h0003, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'hc004, dlt_pkg::RESP_OKAY);
    ev.pulse(0, 2);
    lag();
    rc(ba(dlt_pkg::IDX_T0_CNT), 16'h0002);
    low0 = 0;
    ev.pulse(0, 1);
    lag();
    chk(18'(low0), 18'h1, 18'h1);
    rc(ba(dlt_pkg::IDX_T0_CNT), 16'h0000);
    rc(ba(dlt_pkg::IDX_T0_MODE), 16'h0024);
    ev.pulse(0, 2);
    lag();
    rc(ba(dlt_pkg::IDX_T0_CNT), 16'h0000);
    rc(ba(dlt_pkg::IDX_T0_MODE), 16'h0024);
    wr(ba(dlt_pkg::IDX_T0_MODE), 16'h8004, dlt_pkg::RESP_OKAY);
    rc(ba(dlt_pkg::IDX_T0_MODE), 16'h0004);
    wr(ba(dlt_pkg::IDX_T1_CNT), 16'h0000, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T1_LIMA), 16'h0002, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T1_LIMB), 16'h0003, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T1_MODE), 16'he006, dlt_pkg::RESP_OKAY);
    irq1 = 0;
    ev.pulse(1, 2);
    lag();
    chk({17'h0, timer_out[1]}, 18'h0, 18'h0);
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'hb026);
    wr(ba(dlt_pkg::IDX_T1_MODE), 16'h2006, dlt_pkg::RESP_OKAY);
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'hb006);
    ev.pulse(1, 3);
    lag();
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'h2026);
    chk({17'h0, timer_out[1]}, 18'h1, 18'h1);
    chk(18'(irq1), 18'h2, 18'h2);
    wr(ba(dlt_pkg::IDX_T1_CNT), 16'hfffe, dlt_pkg::RESP_OKAY);
    wr(ba(dlt_pkg::IDX_T1_MODE), 16'hc005, dlt_pkg::RESP_OKAY);
    ev.pulse(1, 2);
    lag();
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'h8005);
    ev.pulse(1, 2);
    lag();
    rc(ba(dlt_pkg::IDX_T1_CNT), 16'h0000);
    rc(ba(dlt_pkg::IDX_T1_MODE), 16'h8025);
    summarize();
  end
endmodule
